/* design/fpseq_sync.sv */
// two-flop synchroniser for the comparator inputs
module fpseq_sync #(parameter int W = 5) (
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    // ==========================================================
    // double register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

/* design/fpseq_timer.sv */
// interval down counter: expired holds while count is zero
module fpseq_timer (
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    fpseq_tmr_if.tmr  t
);
    logic [23:0] cnt_reg;
    assign t.expired = (cnt_reg == 24'h000000);
    // ==========================================================
    // load on start, count down to zero
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cnt_reg <= 24'h000000;
        end else if (t.start) begin
            cnt_reg <= t.load;
        end else if (cnt_reg != 24'h000000) begin
            cnt_reg <= cnt_reg - 24'h000001;
        end
    end
endmodule

/* design/fpseq_top.sv */
// four rail power sequencer and supervisor
`include "fpseq_map.svh"
module fpseq_top
    import fpseq_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        start_i,
    input  wire logic [3:0]  rail_sense_inputs_i,
    input  wire logic [7:0]  up_delay_nf_i,
    input  wire logic [7:0]  dn_delay_nf_i,
    input  wire logic        pgt_enable_i,
    input  wire logic [23:0] pgt_cycles_i,
    input  wire logic        fault_line_i,
    output logic             fault_line_o,
    output logic             fault_line_oe_o,
    output logic             done_n_o,
    output logic             done_n_oe_o,
    output logic [3:0]       supply_enable_outputs_o,
    output logic             delay_timer_pin_o
);
    // ==========================================================
    // synchronised comparator results
    logic [4:0] sync_q;
    logic [3:0] rail_up;
    logic       start_s;
    fpseq_sync #(.W(5)) u_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .d_i        ({start_i, rail_sense_inputs_i}),
        .q_o        (sync_q)
    );
    assign rail_up = sync_q[3:0];
    assign start_s = sync_q[4];

    // ==========================================================
    // interval timers
    fpseq_tmr_if dly_if ();
    fpseq_tmr_if pgt_if ();
    fpseq_timer u_dly (.core_clk_i(core_clk_i), .srst_i(srst_i), .t(dly_if));
    fpseq_timer u_pgt (.core_clk_i(core_clk_i), .srst_i(srst_i), .t(pgt_if));

    fpseq_state_e state_reg, state_next;
    logic [1:0]   idx_reg, idx_next;
    logic [3:0]   en_reg, en_next;
    logic         done_reg, done_next;
    logic         int_fault_reg, int_fault_next;
    logic         pgt_run_reg, pgt_run_next;

    // ==========================================================
    // delay loads from capacitance settings
    logic [23:0] up_load, dn_load;
    logic        ext_fault, rail_low, all_low, pgt_fail;
    assign up_load = 24'(up_delay_nf_i * `FPSEQ_DLY_CYC_PER_NF);
    assign dn_load = 24'(dn_delay_nf_i * `FPSEQ_DLY_CYC_PER_NF);
    assign ext_fault = !fault_line_i && !fault_line_oe_o;
    assign rail_low  = |(en_reg & ~rail_up & ~(4'h1 << idx_reg)
                         | (en_reg & ~rail_up & {4{state_reg == FPSEQ_SUPERVISE}}));
    assign all_low   = (rail_up == 4'h0) && !start_s;
    assign pgt_fail  = pgt_run_reg && pgt_enable_i && pgt_if.expired;

    // ==========================================================
    // sequencing state machine
    always_comb begin
        state_next     = state_reg;
        idx_next       = idx_reg;
        en_next        = en_reg;
        done_next      = done_reg;
        int_fault_next = int_fault_reg;
        pgt_run_next   = pgt_run_reg;
        dly_if.start   = 1'b0;
        dly_if.load    = up_load;
        pgt_if.start   = 1'b0;
        pgt_if.load    = pgt_cycles_i;
        case (state_reg)
            FPSEQ_OFF: begin
                if (start_s) begin
                    state_next   = FPSEQ_UP_DELAY;
                    idx_next     = 2'd0;
                    dly_if.start = 1'b1;
                end
            end
            FPSEQ_UP_DELAY: begin
                if (!start_s) begin
                    state_next = FPSEQ_FAULT;
                    int_fault_next = 1'b1;
                end else if (dly_if.expired) begin
                    en_next[idx_reg] = 1'b1;
                    state_next       = FPSEQ_UP_WAIT;
                    pgt_if.start     = 1'b1;
                    pgt_run_next     = 1'b1;
                end
            end
            FPSEQ_UP_WAIT: begin
                if (!start_s || pgt_fail) begin
                    state_next = FPSEQ_FAULT;
                    int_fault_next = 1'b1;
                end else if (rail_up[idx_reg]) begin
                    pgt_run_next = 1'b0;
                    if (idx_reg == 2'd3) begin
                        done_next  = 1'b1;
                        state_next = FPSEQ_SUPERVISE;
                    end else begin
                        idx_next     = idx_reg + 2'd1;
                        dly_if.start = 1'b1;
                        state_next   = FPSEQ_UP_DELAY;
                    end
                end
            end
            FPSEQ_SUPERVISE: begin
                if (!start_s) begin
                    state_next   = FPSEQ_DN_DELAY;
                    idx_next     = 2'd3;
                    dly_if.start = 1'b1;
                    dly_if.load  = dn_load;
                end
            end
            FPSEQ_DN_DELAY: begin
                if (start_s) begin
                    state_next = FPSEQ_FAULT;
                    int_fault_next = 1'b1;
                end else if (dly_if.expired) begin
                    en_next[idx_reg] = 1'b0;
                    state_next       = FPSEQ_DN_WAIT;
                end
            end
            FPSEQ_DN_WAIT: begin
                if (start_s) begin
                    state_next = FPSEQ_FAULT;
                    int_fault_next = 1'b1;
                end else if (!rail_up[idx_reg]) begin
                    if (idx_reg == 2'd0) begin
                        done_next  = 1'b0;
                        state_next = FPSEQ_OFF;
                    end else begin
                        idx_next     = idx_reg - 2'd1;
                        dly_if.start = 1'b1;
                        dly_if.load  = dn_load;
                        state_next   = FPSEQ_DN_DELAY;
                    end
                end
            end
            FPSEQ_FAULT: begin
                // our own pull is masked from ext_fault, so a foreign pull or any input still high holds us here
                if (all_low && !ext_fault) begin
                    state_next     = FPSEQ_OFF;
                    int_fault_next = 1'b0;
                    done_next      = 1'b0;
                end
            end
            default: state_next = FPSEQ_OFF;
        endcase
        // rail faults override every state but OFF and FAULT, external pulls every state but FAULT
        if (state_reg != FPSEQ_FAULT && state_reg != FPSEQ_OFF && rail_low) begin
            state_next     = FPSEQ_FAULT;
            int_fault_next = 1'b1;
        end
        if (state_reg != FPSEQ_FAULT && ext_fault) begin
            state_next = FPSEQ_FAULT;
        end
        if (state_next == FPSEQ_FAULT) begin
            en_next      = 4'h0;
            pgt_run_next = 1'b0;
            done_next    = done_reg;
        end
    end

    // ==========================================================
    // state registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg     <= FPSEQ_OFF;
            idx_reg       <= 2'd0;
            en_reg        <= 4'h0;
            done_reg      <= 1'b0;
            int_fault_reg <= 1'b0;
            pgt_run_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            idx_reg       <= idx_next;
            en_reg        <= en_next;
            done_reg      <= done_next;
            int_fault_reg <= int_fault_next;
            pgt_run_reg   <= pgt_run_next;
        end
    end

    // ==========================================================
    // pins: open-drain lines only ever drive low
    assign supply_enable_outputs_o = en_reg;
    assign done_n_o          = 1'b0;
    assign done_n_oe_o       = done_reg;
    assign fault_line_o      = 1'b0;
    assign fault_line_oe_o   = int_fault_reg;
    assign delay_timer_pin_o = int_fault_reg;

    // ==========================================================
    // checks
    sequence s_start_rise;
        (state_reg == FPSEQ_OFF) && start_s && !ext_fault;
    endsequence
    AST_START_BEGINS: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_start_rise |=> state_reg == FPSEQ_UP_DELAY)
        else $error("start did not begin power-up");
    AST_FAULT_DROPS: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg != FPSEQ_FAULT && ext_fault) |=> en_reg == 4'h0)
        else $error("external fault left an enable high");
    AST_DONE_AT_TOP: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $rose(done_reg) |-> en_reg == 4'hf)
        else $error("done asserted before all rails enabled");
    AST_FAULT_HOLD: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_FAULT && !all_low) |=> state_reg == FPSEQ_FAULT)
        else $error("fault released while inputs high");
    AST_TMR_PIN: assert property (@(posedge core_clk_i) disable iff (srst_i)
        delay_timer_pin_o |-> fault_line_oe_o && state_reg == FPSEQ_FAULT)
        else $error("timer pin high without internal fault");
    AST_REVERSE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_DN_WAIT) |-> en_reg == (4'hf >> (4 - 32'(idx_reg))) )
        else $error("power-down order broken");
    AST_DONE_RELEASE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $fell(done_reg) && state_reg == FPSEQ_OFF |-> $past(en_reg) == 4'h0)
        else $error("done released with rails enabled");
    AST_PGT: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_UP_WAIT && pgt_fail) |=> state_reg == FPSEQ_FAULT)
        else $error("power-good timeout not flagged");
    AST_EARLY_OFF: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_UP_WAIT && !start_s) |=> int_fault_reg)
        else $error("start dropped during power-up without fault");

    // ==========================================================
    // further checks: power-up steps
    sequence s_up_step;
        (state_reg == FPSEQ_UP_DELAY) && start_s && dly_if.expired
            && !rail_low && !ext_fault;
    endsequence
    sequence s_rail_added;
        (state_reg == FPSEQ_UP_WAIT) && (en_reg == ($past(en_reg) | (4'h1 << $past(idx_reg))));
    endsequence
    AST_UP_STEP: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_up_step |=> s_rail_added)
        else $error("enable did not follow the start-up delay");
    AST_ZERO_UP: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (s_start_rise ##0 (up_delay_nf_i == 8'h00)) |=> dly_if.expired)
        else $error("unset start-up delay not zero");
    AST_UP_SHAPE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_UP_WAIT) |-> en_reg == (4'hf >> (3 - 32'(idx_reg))))
        else $error("power-up enables out of order");
    AST_UP_DELAY_SHAPE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_UP_DELAY) |-> en_reg == (4'hf >> (4 - 32'(idx_reg))))
        else $error("rail enabled before its delay ended");
    AST_RAIL_EARLY: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_UP_DELAY && idx_reg != 2'd0 && !rail_up[0]) |=>
            state_reg == FPSEQ_FAULT)
        else $error("enabled rail low during power-up not flagged");
    AST_PGT_OFF: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_UP_WAIT && !pgt_enable_i && start_s && !rail_low && !ext_fault)
            |=> state_reg != FPSEQ_FAULT)
        else $error("disabled power-good timeout still faulted");

    // power-down steps
    sequence s_dn_step;
        (state_reg == FPSEQ_DN_DELAY) && !start_s && dly_if.expired
            && !rail_low && !ext_fault;
    endsequence
    sequence s_rail_removed;
        (state_reg == FPSEQ_DN_WAIT) && (en_reg == ($past(en_reg) & ~(4'h1 << $past(idx_reg))));
    endsequence
    AST_DN_STEP: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_dn_step |=> s_rail_removed)
        else $error("disable did not follow the shut-down delay");
    AST_DN_LOAD: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_SUPERVISE && !start_s) |-> dly_if.start && dly_if.load == dn_load)
        else $error("power-down not timed by the shut-down delay");
    AST_ZERO_DN: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_SUPERVISE && !start_s && dn_delay_nf_i == 8'h00) |=> dly_if.expired)
        else $error("unset shut-down delay not zero");
    AST_DN_START: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ((state_reg == FPSEQ_DN_DELAY || state_reg == FPSEQ_DN_WAIT) && start_s) |=>
            state_reg == FPSEQ_FAULT && int_fault_reg)
        else $error("start high during power-down without fault");

    // fault handling and input timing
    AST_SUPERVISE_DROP: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_SUPERVISE && rail_up != 4'hf) |=> en_reg == 4'h0 && fault_line_oe_o)
        else $error("rail loss in supervise not handled");
    AST_INT_TMR: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_SUPERVISE && rail_up != 4'hf) |=> delay_timer_pin_o)
        else $error("internal fault left timer pin low");
    AST_EXT_QUIET: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_OFF && ext_fault) |=> !delay_timer_pin_o)
        else $error("external fault raised the timer pin");
    AST_FAULT_EXIT: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_reg == FPSEQ_FAULT && all_low && !ext_fault) |=>
            state_reg == FPSEQ_OFF && !fault_line_oe_o)
        else $error("fault not released with inputs low");
    AST_SYNC_LAG: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $rose(start_s) |-> $past(start_i, 2))
        else $error("start seen without two-flop lag");
endmodule

/* pkg/fpseq_map.svh */
// constants of the four rail power sequencer
`ifndef FPSEQ_MAP_SVH
`define FPSEQ_MAP_SVH
// ==========================================================
// widths and timing
`define FPSEQ_NUM_RAILS      4
`define FPSEQ_CNT_W          24
`define FPSEQ_CLK_MHZ        100
// delay scale, microseconds per nanofarad, and its cycle count
`define FPSEQ_DLY_US_PER_NF  200
`define FPSEQ_DLY_CYC_PER_NF (`FPSEQ_DLY_US_PER_NF * `FPSEQ_CLK_MHZ)
// default delays in nanofarads, power-good timeout in cycles
`define FPSEQ_UP_NF_DEF      1
`define FPSEQ_DN_NF_DEF      1
`define FPSEQ_PGT_CYC_DEF    40000
`endif

/* pkg/fpseq_pkg.sv */
// types of the four rail power sequencer
package fpseq_pkg;
    typedef enum logic [2:0] {
        FPSEQ_OFF,
        FPSEQ_UP_DELAY,
        FPSEQ_UP_WAIT,
        FPSEQ_SUPERVISE,
        FPSEQ_DN_DELAY,
        FPSEQ_DN_WAIT,
        FPSEQ_FAULT
    } fpseq_state_e;
endpackage

/* pkg/fpseq_tmr_if.sv */
// interface between the sequencer and its interval timers
interface fpseq_tmr_if;
    logic        start;
    logic [23:0] load;
    logic        expired;
    modport ctl (output start, output load, input expired);
    modport tmr (input start, input load, output expired);
endinterface

/* verif/fpseq_ctrl_model.sv */
// partner model: controller start line, four rail supplies, fault wire
module fpseq_ctrl_model (
    input  wire logic       core_clk_i,
    input  wire logic       start_req_i,
    input  wire logic       pull_fault_i,
    input  wire logic [3:0] hold_low_i,
    input  wire logic [3:0] enable_i,
    input  wire logic       fault_oe_i,
    output logic            start_o,
    output logic [3:0]      rail_sense_o,
    output logic            fault_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // rails ramp four cycles behind their enables, hold_low sticks a rail low
    logic [3:0] ramp_reg [4] = '{default: 4'h0};
    always @(posedge core_clk_i) begin
        ramp_reg[0] <= enable_i & ~hold_low_i;
        for (int i = 1; i < 4; i++) begin
            ramp_reg[i] <= ramp_reg[i-1];
        end
    end
    // sense outputs, start level and the pulled-up fault wire
    assign rail_sense_o = ramp_reg[3] & ~hold_low_i;
    assign start_o      = start_req_i;
    assign fault_line_o = ~(fault_oe_i | pull_fault_i);
endmodule

/* verif/fpseq_top_tb.sv */
// self-checking bench of the four rail power sequencer
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module fpseq_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // clock, stimulus and observed signals
    logic        core_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        start_req = 1'b0, pull_fault = 1'b0, pgt_en = 1'b1;
    logic [3:0]  hold_low = 4'h0;
    logic [7:0]  up_nf = 8'h00, dn_nf = 8'h00;
    logic [23:0] pgt_cyc = 24'h000032;
    logic        start_w, flt_w, flt_o, flt_oe, done_o, done_oe, tmr_o;
    logic [3:0]  sense_w, en_o;
    int          err_count = 0, checks_done = 0, cycles = 0;
    always #5 core_clk_i = ~core_clk_i;
    // design and partner
    fpseq_top u_fpseq_top (.core_clk_i(core_clk_i), .srst_i(srst_i), .start_i(start_w),
        .rail_sense_inputs_i(sense_w), .up_delay_nf_i(up_nf), .dn_delay_nf_i(dn_nf),
        .pgt_enable_i(pgt_en), .pgt_cycles_i(pgt_cyc), .fault_line_i(flt_w),
        .fault_line_o(flt_o), .fault_line_oe_o(flt_oe), .done_n_o(done_o),
        .done_n_oe_o(done_oe), .supply_enable_outputs_o(en_o), .delay_timer_pin_o(tmr_o));
    fpseq_ctrl_model u_fpseq_ctrl_model (.core_clk_i(core_clk_i), .start_req_i(start_req),
        .pull_fault_i(pull_fault), .hold_low_i(hold_low), .enable_i(en_o),
        .fault_oe_i(flt_oe), .start_o(start_w), .rail_sense_o(sense_w),
        .fault_line_o(flt_w));
    // ==========================================================
    // helpers: all driving and sampling one nanosecond after the edge
    task automatic tick(input int n = 1);
        repeat (n) begin @(posedge core_clk_i); #1; end
    endtask
    task automatic wait_en(input logic [3:0] v, input int lim);
        for (int i = 0; i < lim && en_o !== v; i++) tick();
    endtask
    task automatic wait_flt(input logic v, input int lim);
        for (int i = 0; i < lim && flt_oe !== v; i++) tick();
    endtask
    task automatic end_test(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, err_count);
    endtask
    // walk the enables up or down one rail at a time
    task automatic ramp(input bit up);
        logic [3:0] v;
        for (int k = 0; k < 4; k++) begin
            v = up ? 4'((5'h01 << (k + 1)) - 5'h01) : 4'(4'hf >> (k + 1));
            wait_en(v, 100);
            `CHK("enables", v, en_o)
        end
    endtask
    // release everything and let the fault state clear
    task automatic recover();
        start_req = 1'b0;
        hold_low = 4'h0;
        pull_fault = 1'b0;
        wait_flt(1'b0, 50);
        tick(12);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_sequence();
        start_req = 1'b1;
        ramp(1'b1);
        for (int i = 0; i < 20 && done_oe !== 1'b1; i++) tick();
        `CHK("done pulled", 1'b1, done_oe)
        `CHK("done level", 1'b0, done_o)
        start_req = 1'b0;
        ramp(1'b0);
        for (int i = 0; i < 20 && done_oe !== 1'b0; i++) tick();
        `CHK("done released", 1'b0, done_oe)
        `CHK("no fault", 1'b0, flt_oe)
        end_test("sequence");
    endtask
    task automatic t_rail_drop();
        start_req = 1'b1;
        ramp(1'b1);
        tick(10);
        hold_low = 4'h2;
        wait_flt(1'b1, 20);
        `CHK("fault pulled", 1'b1, flt_oe)
        `CHK("fault level", 1'b0, flt_o)
        `CHK("enables off", 4'h0, en_o)
        `CHK("timer pin", 1'b1, tmr_o)
        tick(20);
        `CHK("fault held", 1'b1, flt_oe)
        recover();
        `CHK("fault cleared", 1'b0, flt_oe)
        end_test("rail_drop");
    endtask
    task automatic t_timeout();
        pgt_cyc = 24'h000020;
        hold_low = 4'h1;
        start_req = 1'b1;
        wait_en(4'h1, 100);
        tick(32);
        `CHK("timeout not yet", 1'b0, flt_oe)
        tick(1);
        `CHK("timeout fault", 1'b1, flt_oe)
        `CHK("timeout timer pin", 1'b1, tmr_o)
        recover();
        pgt_en = 1'b0;
        hold_low = 4'h1;
        start_req = 1'b1;
        wait_en(4'h1, 100);
        tick(200);
        `CHK("no timeout", 1'b0, flt_oe)
        `CHK("rail one waits", 4'h1, en_o)
        start_req = 1'b0;
        wait_flt(1'b1, 20);
        `CHK("early start low", 1'b1, flt_oe)
        recover();
        pgt_en = 1'b1;
        pgt_cyc = 24'h000032;
        end_test("timeout");
    endtask
    task automatic t_delays();
        up_nf = 8'h01;
        start_req = 1'b1;
        tick(19990);
        `CHK("start-up delay", 4'h0, en_o)
        wait_en(4'h1, 40);
        `CHK("rail one on", 4'h1, en_o)
        pull_fault = 1'b1;
        tick(4);
        `CHK("ext abort", 4'h0, en_o)
        `CHK("ext timer pin", 1'b0, tmr_o)
        `CHK("ext not driven", 1'b0, flt_oe)
        recover();
        up_nf = 8'h00;
        dn_nf = 8'h01;
        start_req = 1'b1;
        ramp(1'b1);
        for (int i = 0; i < 20 && done_oe !== 1'b1; i++) tick();
        `CHK("done before power-down", 1'b1, done_oe)
        start_req = 1'b0;
        tick(19990);
        `CHK("shut-down delay", 4'hf, en_o)
        wait_en(4'h7, 40);
        `CHK("rail four off", 4'h7, en_o)
        pull_fault = 1'b1;
        tick(4);
        `CHK("ext abort down", 4'h0, en_o)
        recover();
        dn_nf = 8'h00;
        end_test("delays");
    endtask
    // ==========================================================
    // verdict and hang guard
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        tick(3);
        srst_i = 1'b0;
        tick(5);
        `CHK("reset done", 1'b0, done_oe)
        t_sequence();
        t_rail_drop();
        t_timeout();
        t_delays();
        test_done();
    end
endmodule
